/* File: core/pfbw_writer.sv */
// top of the program flash block writer
// assumes core accesses are one-cycle strobes synchronous to clk
// and a flash array that accepts one byte program per cycle
//
// Overview of operation
// - flash is programmed only as whole sixteen-byte, eight-word blocks
// - sixteen byte holding registers, each loaded by one table store
// - a table store only updates a holding register, never the array
// - core execution is stalled for the whole long write
// - the internal programming timer ends every long write
// - one block write stalls the core for about two milliseconds
// - holding registers return to FFh on reset and after each write
// - a holding byte of FFh leaves its flash byte unchanged
// - programming only clears bits, never sets a zero to one
// - setting the start and write-enable bits after unlocking, with config select clear, begins the flash write
// - a full 64-byte row update takes about eight milliseconds
`timescale 1ns/1ns
`default_nettype none
module pfbw_writer
#(
  parameter int unsigned WRITE_CYCLES = pfbw_pkg::WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // table store from the core
  input wire pfbw_pkg::pfbw_tbl_wr_t tbl_wr,
  // unlock key register write
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  // memory control register write and readback
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_data,
  output logic [7:0] ctrl_rd,
  // core stall
  output logic core_stall,
  // flash array program port
  output pfbw_pkg::pfbw_flash_wr_t flash_wr,
  output logic write_done
);

  //////////////////////////////////////////////////////////////////////
  // control register bits

  logic start_q;
  logic write_enable_bit_q;
  logic config_space_select_q;
  pfbw_pkg::pfbw_key_t key_q;
  pfbw_pkg::pfbw_seq_t seq_q;
  logic [pfbw_pkg::ADDR_W-1:0] ptr_q;
  logic [pfbw_pkg::IDX_W-1:0] idx_q;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic start_ok;
  logic burn_last;
  logic [7:0] hold_byte;
  logic hold_clear;
  logic burned_q;

  //////////////////////////////////////////////////////////////////////
  // shared decoding

  // a control byte that asks for a program memory write
  function automatic logic wants_write(input logic [7:0] c);
    return c[pfbw_pkg::CTRL_START_POS]
      && c[pfbw_pkg::CTRL_WRITE_ENABLE_BIT_POS]
      && !c[pfbw_pkg::CTRL_CONFIG_SPACE_SELECT_POS];
  endfunction

  // erased bytes need no array pulse
  function automatic logic needs_burn(input logic [7:0] b);
    return b != pfbw_pkg::HOLD_RESET;
  endfunction

  // array address of one byte of the held block
  function automatic logic [pfbw_pkg::ADDR_W-1:0] block_addr(
    input logic [pfbw_pkg::ADDR_W-1:0] ptr,
    input logic [pfbw_pkg::IDX_W-1:0] idx);
    return {ptr[pfbw_pkg::ADDR_W-1:pfbw_pkg::IDX_W], idx};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // start request and settings

  assign start_ok = ctrl_wr && wants_write(ctrl_data)
    && key_q == pfbw_pkg::PFBW_ARMED && !start_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      write_enable_bit_q <= 1'b0;
    else if (ctrl_wr && !start_q)
      write_enable_bit_q <= ctrl_data[pfbw_pkg::CTRL_WRITE_ENABLE_BIT_POS];
  end

  // settings are frozen while a long write runs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      config_space_select_q <= 1'b0;
    else if (ctrl_wr && !start_q)
      config_space_select_q <= ctrl_data[pfbw_pkg::CTRL_CONFIG_SPACE_SELECT_POS];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      start_q <= 1'b0;
    else if (start_ok)
      start_q <= 1'b1;
    else if (seq_q == pfbw_pkg::PFBW_DONE)
      start_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_rd <= pfbw_pkg::CTRL_RESET;
    else
    begin
      ctrl_rd <= '0;
      ctrl_rd[pfbw_pkg::CTRL_START_POS] <= start_q;
      ctrl_rd[pfbw_pkg::CTRL_WRITE_ENABLE_BIT_POS] <= write_enable_bit_q;
      ctrl_rd[pfbw_pkg::CTRL_CONFIG_SPACE_SELECT_POS] <= config_space_select_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // unlock key tracking; any other key write or a control write disarms

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      key_q <= pfbw_pkg::PFBW_IDLE;
    else if (key_wr)
    begin
      if (key_data == pfbw_pkg::UNLOCK_KEY1)
        key_q <= pfbw_pkg::PFBW_KEY1;
      else if (key_data == pfbw_pkg::UNLOCK_KEY2
               && key_q == pfbw_pkg::PFBW_KEY1)
        key_q <= pfbw_pkg::PFBW_ARMED;
      else
        key_q <= pfbw_pkg::PFBW_IDLE;
    end
    else if (ctrl_wr)
      key_q <= pfbw_pkg::PFBW_IDLE;
  end

  //////////////////////////////////////////////////////////////////////
  // table pointer tracks last store; block base is taken from it

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_q <= '0;
    else if (tbl_wr.valid && !start_q)
      ptr_q <= tbl_wr.addr;
  end

  pfbw_hold_regs u_hold
  (
    .clk(clk),
    .rst(rst),
    .load(tbl_wr.valid && !start_q),
    .load_idx(tbl_wr.addr[pfbw_pkg::IDX_W-1:0]),
    .load_data(tbl_wr.data),
    .clear(hold_clear),
    .rd_idx(idx_q),
    .rd_data(hold_byte)
  );

  //////////////////////////////////////////////////////////////////////
  // long write sequence: burn sixteen bytes, then wait for the timer

  assign tmr_start = start_ok;
  assign burn_last = idx_q == pfbw_pkg::IDX_W'(pfbw_pkg::BLOCK_BYTES - 1);
  assign hold_clear = seq_q == pfbw_pkg::PFBW_DONE;

  pfbw_prog_timer #(.CYCLES(WRITE_CYCLES)) u_tmr
  (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_q <= pfbw_pkg::PFBW_WAIT;
      idx_q <= '0;
    end
    else
    begin
      unique case (seq_q)
        pfbw_pkg::PFBW_WAIT:
          if (start_ok)
          begin
            seq_q <= pfbw_pkg::PFBW_BURN;
            idx_q <= '0;
          end
        pfbw_pkg::PFBW_BURN:
          if (!burn_last)
            idx_q <= idx_q + 1'b1;
          else if (tmr_done)
            seq_q <= pfbw_pkg::PFBW_DONE;
        pfbw_pkg::PFBW_DONE:
          seq_q <= pfbw_pkg::PFBW_WAIT;
        default:
          seq_q <= pfbw_pkg::PFBW_WAIT;
      endcase
    end
  end

  // one pass over the block per long write; the index parks on the
  // last byte while the timer runs and must not pulse the array again
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      burned_q <= 1'b0;
    else if (start_ok)
      burned_q <= 1'b0;
    else if (seq_q == pfbw_pkg::PFBW_BURN && burn_last)
      burned_q <= 1'b1;
  end

  // bytes of FFh are skipped, so the array only ever clears bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flash_wr <= '0;
    else
    begin
      flash_wr.valid <= seq_q == pfbw_pkg::PFBW_BURN && !burned_q
        && needs_burn(hold_byte) && tmr_busy;
      flash_wr.addr <= block_addr(ptr_q, idx_q);
      flash_wr.data <= hold_byte;
    end
  end

  // stall from the start write until the sequence returns to wait;
  // four of these stalls make up one row update
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      core_stall <= 1'b0;
    else
      core_stall <= start_ok
        || (seq_q != pfbw_pkg::PFBW_WAIT
            && seq_q != pfbw_pkg::PFBW_DONE);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      write_done <= 1'b0;
    else
      write_done <= seq_q == pfbw_pkg::PFBW_DONE;
  end

endmodule
`default_nettype wire

/* File: inc/pfbw_pkg.sv */
// package for the program flash block writer
// shared constants and carrier structs; no surroundings assumed
package pfbw_pkg;

  localparam int unsigned BLOCK_BYTES = 16;
  localparam int unsigned BLOCK_WORDS = 8;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned ADDR_W = 14;
  localparam logic [7:0] HOLD_RESET = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // memory control register field positions
  localparam int unsigned CTRL_START_POS = 1;
  localparam int unsigned CTRL_WRITE_ENABLE_BIT_POS = 2;
  localparam int unsigned CTRL_CONFIG_SPACE_SELECT_POS = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // block write time and its cycle count at 250 MHz
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned WRITE_TIME_US = 2000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W = 20;

  typedef enum logic [1:0] {
    PFBW_IDLE = 2'b00,
    PFBW_KEY1 = 2'b01,
    PFBW_ARMED = 2'b10
  } pfbw_key_t;

  typedef enum logic [1:0] {
    PFBW_WAIT = 2'b00,
    PFBW_BURN = 2'b01,
    PFBW_DONE = 2'b10
  } pfbw_seq_t;

  // one table store from the core
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } pfbw_tbl_wr_t;

  // one byte passed to the flash array
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } pfbw_flash_wr_t;

endpackage

/* File: core/pfbw_hold_regs.sv */
// sixteen byte-wide holding registers loaded by table stores
// assumes a single clock and an async active-high reset
`timescale 1ns/1ns
`default_nettype none
module pfbw_hold_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load port
  input wire logic load,
  input wire logic [pfbw_pkg::IDX_W-1:0] load_idx,
  input wire logic [7:0] load_data,
  // clear back to erased value
  input wire logic clear,
  // read port
  input wire logic [pfbw_pkg::IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data
);

  logic [7:0] hold_q [pfbw_pkg::BLOCK_BYTES];

  // a store takes priority so a byte loaded at clear time survives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < pfbw_pkg::BLOCK_BYTES; i++)
        hold_q[i] <= pfbw_pkg::HOLD_RESET;
    end
    else
    begin
      for (int i = 0; i < pfbw_pkg::BLOCK_BYTES; i++)
      begin
        if (load && load_idx == i[pfbw_pkg::IDX_W-1:0])
          hold_q[i] <= load_data;
        else if (clear)
          hold_q[i] <= pfbw_pkg::HOLD_RESET;
      end
    end
  end

  assign rd_data = hold_q[rd_idx];

endmodule
`default_nettype wire

/* File: core/pfbw_prog_timer.sv */
// programming timer that bounds one long write
// assumes start is a one-cycle pulse while idle
`timescale 1ns/1ns
`default_nettype none
module pfbw_prog_timer
#(
  parameter int unsigned CYCLES = pfbw_pkg::WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam logic [pfbw_pkg::TMR_W-1:0] LAST =
    pfbw_pkg::TMR_W'(CYCLES - 1);

  logic [pfbw_pkg::TMR_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        cnt_q <= '0;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (cnt_q == LAST)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule
`default_nettype wire

/* File: sim/pfbw_writer_assertions.sv */
// checker on the block writer top ports
// assumes one clock and the async active-high reset
`timescale 1ns/1ns
`default_nettype none
module pfbw_writer_assertions
#(
  parameter int unsigned WRITE_CYCLES = 40
)
(
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire pfbw_pkg::pfbw_tbl_wr_t tbl_wr,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_data,
  input wire logic [7:0] ctrl_rd,
  input wire logic core_stall,
  input wire pfbw_pkg::pfbw_flash_wr_t flash_wr,
  input wire logic write_done
);
  // slack: the stall length is only pinned to a few cycles
  localparam int LO = WRITE_CYCLES - 2;
  localparam int HI = WRITE_CYCLES + 4;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_start_unlocked:
    assert property (!core_stall && key_wr && key_data == 8'h55 ##1 key_wr
      && key_data == 8'hAA ##1 ctrl_wr && ctrl_data == 8'h06 |=> core_stall)
    else $error("no stall after unlock and start");
  a_write_enable_bit_needed:
    assert property (ctrl_wr && !ctrl_data[2] && !core_stall |=> !core_stall)
    else $error("start taken without write enable");
  a_stall_ends:
    assert property ($rose(core_stall) |-> ##[LO:HI] $fell(core_stall))
    else $error("stall length wrong");
  a_stall_holds:
    assert property ($rose(core_stall) |-> core_stall[*8])
    else $error("stall dropped early");
  a_done_unstalls:
    assert property (write_done |-> !core_stall && $past(core_stall))
    else $error("done pulse not at stall end");
  a_start_bit_set:
    assert property ($rose(core_stall) |-> ##[0:1] ctrl_rd[1])
    else $error("start bit not shown");
  a_start_bit_clear:
    assert property (write_done |-> ##[0:2] !ctrl_rd[1])
    else $error("start bit not cleared");
  a_flash_in_stall:
    assert property (flash_wr.valid |-> core_stall)
    else $error("array written outside long write");
  a_skip_erased:
    assert property (flash_wr.valid |-> flash_wr.data != 8'hFF)
    else $error("erased byte sent to array");
  c_stall: cover property ($rose(core_stall));
  c_done: cover property (write_done);
  c_flash: cover property (flash_wr.valid);
endmodule
bind pfbw_writer pfbw_writer_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .tbl_wr(tbl_wr), .key_wr(key_wr),
  .key_data(key_data), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data),
  .ctrl_rd(ctrl_rd), .core_stall(core_stall), .flash_wr(flash_wr),
  .write_done(write_done));
`default_nettype wire

/* File: sim/pfbw_core_model.sv */
// processor core model issuing table stores and register writes
// assumes the block samples strobes on rising clk
`timescale 1ns/1ns
`default_nettype none
module pfbw_core_model
(
  // clock and stall
  input wire logic clk,
  input wire logic core_stall,
  // writes toward the block
  output pfbw_pkg::pfbw_tbl_wr_t tbl_wr,
  output logic key_wr,
  output logic [7:0] key_data,
  output logic ctrl_wr,
  output logic [7:0] ctrl_data
);
  initial
  begin
    tbl_wr = '0;
    key_wr = 1'b0;
    key_data = 8'h00;
    ctrl_wr = 1'b0;
    ctrl_data = 8'h00;
  end
  // kind 0 table store, 1 key, 2 control, other idle
  task automatic acc(input int kind, input logic [13:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    while (core_stall === 1'b1)
      @(posedge clk);
    tbl_wr <= '{valid: kind == 0, addr: a, data: d};
    key_wr <= kind == 1;
    key_data <= d;
    ctrl_wr <= kind == 2;
    ctrl_data <= d;
  endtask
  task automatic idle;
    acc(3, 14'h0000, 8'h00);
  endtask
  // pointer is left on the loaded block
  task automatic start_write(input logic [7:0] c);
    acc(1, 14'h0000, 8'h55);
    acc(1, 14'h0000, 8'hAA);
    acc(2, 14'h0000, c);
    idle();
  endtask
endmodule
`default_nettype wire

/* File: sim/pfbw_writer_tb_top.sv */
// testbench for the program flash block writer
// assumes the core model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module pfbw_writer_tb_top;
  localparam int unsigned WC = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pfbw_pkg::pfbw_tbl_wr_t tbl_wr;
  logic key_wr, ctrl_wr, core_stall, write_done;
  logic [7:0] key_data, ctrl_data, ctrl_rd;
  pfbw_pkg::pfbw_flash_wr_t flash_wr;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [21:0] fq[$];
  always #2 clk = ~clk;
  pfbw_core_model core (.clk(clk), .core_stall(core_stall), .tbl_wr(tbl_wr),
    .key_wr(key_wr), .key_data(key_data), .ctrl_wr(ctrl_wr),
    .ctrl_data(ctrl_data));
  pfbw_writer #(.WRITE_CYCLES(WC)) uut (.clk(clk), .rst(rst),
    .tbl_wr(tbl_wr), .key_wr(key_wr), .key_data(key_data),
    .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data), .ctrl_rd(ctrl_rd),
    .core_stall(core_stall), .flash_wr(flash_wr), .write_done(write_done));
  always @(negedge clk)
    if (flash_wr.valid === 1'b1)
      fq.push_back({flash_wr.addr, flash_wr.data});
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [7:0] pat(input int i);
    return (i == 5) ? 8'hFF : 8'(i * 8'h13);
  endfunction
  task automatic wait_done;
    int n;
    int stall_n;
    n = 0;
    stall_n = 0;
    while (write_done !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
      if (core_stall === 1'b1)
        stall_n++;
    end
    chk({21'h0, write_done}, 22'h1);
    chk(22'(stall_n), 22'(WC + 2));
    repeat (3) @(negedge clk);
    chk({21'h0, ctrl_rd[1]}, 22'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_refuse;
    logic [7:0] cv [3] = '{8'h06, 8'h02, 8'h46};
    for (int k = 0; k < 3; k++)
    begin
      core.acc(1, 14'h0000, k == 0 ? 8'hAA : 8'h55);
      core.acc(1, 14'h0000, k == 0 ? 8'h55 : 8'hAA);
      core.acc(2, 14'h0000, cv[k]);
      core.idle();
      repeat (4) @(negedge clk);
      chk({21'h0, core_stall}, 22'h0);
      chk({14'h0, ctrl_rd}, {14'h0, cv[k] & 8'h44});
    end
  endtask
  task automatic t_block;
    int j;
    fq.delete();
    for (int i = 0; i < 16; i++)
      core.acc(0, 14'h0120 + 14'(i), pat(i));
    core.start_write(8'h06);
    wait_done();
    chk(22'(fq.size()), 22'd15);
    j = 0;
    for (int i = 0; i < 16; i++)
      if (i != 5)
      begin
        chk(fq[j], {14'h0120 + 14'(i), pat(i)});
        j++;
      end
  endtask
  task automatic t_partial;
    fq.delete();
    core.acc(0, 14'h0243, 8'h3C);
    core.start_write(8'h06);
    wait_done();
    chk(22'(fq.size()), 22'd1);
    chk(fq[0], {14'h0243, 8'h3C});
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({13'h0, core_stall, ctrl_rd}, 22'h0);
    t_refuse();
    t_block();
    t_partial();
    end_of_test();
  end
  initial
  begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
